// File: core/spmp_defines.svh
// register offsets, field positions and counts of the serial port
`ifndef SPMP_DEFINES_SVH
`define SPMP_DEFINES_SVH

`define SPMP_OFS_CTRL     8'h30
`define SPMP_OFS_STAT     8'h31
`define SPMP_OFS_DATA     8'h32

`define SPMP_CTRL_RST     8'h00
`define SPMP_BYTE_ZERO    8'h00

`define SPMP_C_IE         7
`define SPMP_C_EN         6
`define SPMP_C_ORDER      5
`define SPMP_C_ROLE       4
`define SPMP_C_CLOCK_POLARITY_BIT       3
`define SPMP_C_CLOCK_PHASE_BIT       2
`define SPMP_C_RATE_HI    1
`define SPMP_C_RATE_LO    0

`define SPMP_S_DONE       7
`define SPMP_S_WRITE_COLLISION_FLAG       6
`define SPMP_S_DBL        0
`define SPMP_S_RSVD       5'h00

`define SPMP_HALF_D4      7'h02
`define SPMP_HALF_D16     7'h08
`define SPMP_HALF_D64     7'h20
`define SPMP_HALF_D128    7'h40
`define SPMP_HALF_D2      7'h01
`define SPMP_HALF_D8      7'h04
`define SPMP_HALF_D32     7'h10

`define SPMP_BITS_FULL    4'h8
`define SPMP_BITS_LAST    4'h7
`define SPMP_EDGE_LAST    4'hF
`define SPMP_CNT_ZERO     4'h0
`define SPMP_CNT_ONE      4'h1
`define SPMP_PTR_ZERO     3'h0
`define SPMP_PTR_ONE      3'h1

`endif

// File: core/spmp_pkg.sv
// types shared by the serial port files
package spmp_pkg;
  typedef logic [7:0] spmp_byte_t;
  typedef enum logic [1:0] {
    MST_IDLE  = 2'b00,
    MST_SHIFT = 2'b01,
    MST_DRAIN = 2'b10
  } spmp_mst_e;
endpackage : spmp_pkg

// File: core/spmp_clkdiv.sv
// half-period enable generator for the master serial clock
`timescale 1ns/1ps
module spmp_clkdiv #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] half,
  // enable out
  output logic                  tick
);
  logic [CNT_W-1:0] cnt_q;

  if (CNT_W < 7) begin : g_chk
    $error("spmp_clkdiv: CNT_W must be at least 7");
  end

  assign tick = run && (cnt_q == half - CNT_W'(1));

  always_ff @(posedge clk) begin
    if (rst || !run || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  a_tick_spacing : assert property (@(posedge clk) disable iff (rst)
    tick && run && $stable(half) |=> !tick || (half == CNT_W'(1)))
    else $error("tick repeated too soon");
endmodule : spmp_clkdiv

// File: core/spmp_core.sv
// byte serial peripheral port, master or slave, with register port
// How it works
// - four modes from polarity and phase bits
// - polarity sets idle level of serial clock
// - phase picks sample edge versus setup edge
// - interrupt when enable, done flag, global enable
// - nothing happens unless port enable set
// - bit order bit picks lsb or msb first
// - role bit selects master or slave
// - low select input demotes master, sets done
// - master clock divided per rate and doubling
// - rate bits ignored while slave
// - done flag set when byte finishes
// - done flag cleared on interrupt acknowledge
// - status read then data access clears done
// - data write while busy sets collision
// - collision read then data access clears both
// - status bits five to one read zero
// - doubling gives two-cycle shortest clock period
// - data write starts shifting the byte in master role only
// - data read returns receive buffer
// - single transmit buffer, double receive buffer
// - master clock stops after eight bits
// - slave output off, clocks ignored, deselected
// - deselect resets slave logic, drops bits
`timescale 1ns/1ps
`include "spmp_defines.svh"
module spmp_core (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic [7:0]          bus_addr,
  input  wire spmp_pkg::spmp_byte_t bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output spmp_pkg::spmp_byte_t     bus_rdata,
  // processor side
  input  wire logic                cpu_gie,
  input  wire logic                irq_ack,
  output logic                     irq,
  // serial pins
  input  wire logic                sck_i,
  output logic                     sck_o,
  output logic                     sck_oe,
  input  wire logic                mosi_i,
  output logic                     mosi_o,
  output logic                     mosi_oe,
  input  wire logic                miso_i,
  output logic                     miso_o,
  output logic                     miso_oe,
  input  wire logic                ss_n_i,
  input  wire logic                ss_is_input
);
  import spmp_pkg::*;

  function automatic logic tx_bit(spmp_byte_t b, logic [2:0] i, logic lsb);
    tx_bit = lsb ? b[i] : b[3'h7 - i];
  endfunction : tx_bit

  function automatic spmp_byte_t shift_in(spmp_byte_t s, logic b, logic lsb);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction : shift_in

  spmp_byte_t ctrl_q;
  logic       flag_q;
  logic       write_collision_flag_q;
  logic       dbl_q;
  logic       arm_f_q;
  logic       arm_w_q;
  spmp_byte_t tx_q;
  spmp_byte_t rx_sh_q;
  spmp_byte_t rx_buf_q;
  spmp_byte_t rdata_q;
  logic [3:0] bitc_q;
  logic [2:0] ptr_q;
  logic       out_q;
  spmp_mst_e  mst_q;
  logic [3:0] edge_q;
  logic       sck_q;
  logic [1:0] samp_p_q;
  logic [1:0] last_p_q;
  logic       sck_m_q;
  logic       sck_s_q;
  logic       sck_p_q;
  logic       mosi_m_q;
  logic       mosi_s_q;
  logic       miso_m_q;
  logic       miso_s_q;
  logic       ss_m_q;
  logic       ss_s_q;

  logic       en;
  logic       master;
  logic       clock_polarity_bit;
  logic       clock_phase_bit;
  logic       lsb;
  logic       ctrl_wr;
  logic       stat_wr;
  logic       stat_rd;
  logic       data_wr;
  logic       data_rd;
  logic       data_acc;
  logic       mode_fault;
  logic       busy;
  logic       start;
  logic       tick;
  logic [6:0] half;
  logic       m_lead;
  logic       m_trail;
  logic       s_active;
  logic       s_rise;
  logic       s_fall;
  logic       lead;
  logic       trail;
  logic       samp;
  logic       setup;
  logic       done;
  logic       eng_idle;
  logic       in_bit;

  assign en     = ctrl_q[`SPMP_C_EN];
  assign master = ctrl_q[`SPMP_C_ROLE];
  assign clock_polarity_bit   = ctrl_q[`SPMP_C_CLOCK_POLARITY_BIT];
  assign clock_phase_bit   = ctrl_q[`SPMP_C_CLOCK_PHASE_BIT];
  assign lsb    = ctrl_q[`SPMP_C_ORDER];

  assign ctrl_wr  = bus_wr && (bus_addr == `SPMP_OFS_CTRL);
  assign stat_wr  = bus_wr && (bus_addr == `SPMP_OFS_STAT);
  assign stat_rd  = bus_rd && (bus_addr == `SPMP_OFS_STAT);
  assign data_wr  = bus_wr && (bus_addr == `SPMP_OFS_DATA);
  assign data_rd  = bus_rd && (bus_addr == `SPMP_OFS_DATA);
  assign data_acc = data_wr || data_rd;

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_m_q  <= 1'b0;
      sck_s_q  <= 1'b0;
      sck_p_q  <= 1'b0;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
      ss_m_q   <= 1'b1;
      ss_s_q   <= 1'b1;
    end else begin
      sck_m_q  <= sck_i;
      sck_s_q  <= sck_m_q;
      sck_p_q  <= sck_s_q;
      mosi_m_q <= mosi_i;
      mosi_s_q <= mosi_m_q;
      miso_m_q <= miso_i;
      miso_s_q <= miso_m_q;
      ss_m_q   <= ss_n_i;
      ss_s_q   <= ss_m_q;
    end
  end

  assign mode_fault = en && master && ss_is_input && !ss_s_q;
  assign s_active   = en && !master && !ss_s_q;
  assign busy       = (mst_q != MST_IDLE) || (s_active && (bitc_q != `SPMP_CNT_ZERO));
  assign start      = data_wr && !busy && en && master && !mode_fault;

  // rate bits reach only the master divider
  always_comb begin
    unique case ({dbl_q, ctrl_q[`SPMP_C_RATE_HI], ctrl_q[`SPMP_C_RATE_LO]})
      3'b000: half = `SPMP_HALF_D4;
      3'b001: half = `SPMP_HALF_D16;
      3'b010: half = `SPMP_HALF_D64;
      3'b011: half = `SPMP_HALF_D128;
      3'b100: half = `SPMP_HALF_D2;
      3'b101: half = `SPMP_HALF_D8;
      3'b110: half = `SPMP_HALF_D32;
      3'b111: half = `SPMP_HALF_D64;
    endcase
  end

  spmp_clkdiv #(
    .CNT_W (7)
  ) u_div (
    .clk  (clk),
    .rst  (rst),
    .run  (mst_q == MST_SHIFT),
    .half (half),
    .tick (tick)
  );

  assign m_lead  = tick && !edge_q[0];
  assign m_trail = tick && edge_q[0];

  // master clock generator
  always_ff @(posedge clk) begin
    if (rst || !en || mode_fault) begin
      mst_q  <= MST_IDLE;
      edge_q <= `SPMP_CNT_ZERO;
      sck_q  <= clock_polarity_bit;
    end else begin
      unique case (mst_q)
        MST_IDLE: begin
          sck_q  <= clock_polarity_bit;
          edge_q <= `SPMP_CNT_ZERO;
          if (start) begin
            mst_q <= MST_SHIFT;
          end
        end
        MST_SHIFT: begin
          if (tick) begin
            sck_q  <= !sck_q;
            edge_q <= edge_q + `SPMP_CNT_ONE;
            if (edge_q == `SPMP_EDGE_LAST) begin
              mst_q <= MST_DRAIN;
            end
          end
        end
        MST_DRAIN: begin
          if (last_p_q[1]) begin
            mst_q <= MST_IDLE;
          end
        end
        default: mst_q <= MST_IDLE;
      endcase
    end
  end

  // master samples lag the edge by the input synchroniser depth
  always_ff @(posedge clk) begin
    if (rst || !en || mode_fault) begin
      samp_p_q <= 2'b00;
      last_p_q <= 2'b00;
    end else begin
      samp_p_q <= {samp_p_q[0], clock_phase_bit ? m_trail : m_lead};
      last_p_q <= {last_p_q[0], m_trail && (edge_q == `SPMP_EDGE_LAST)};
    end
  end

  assign s_rise = sck_s_q && !sck_p_q;
  assign s_fall = !sck_s_q && sck_p_q;

  // shared shift engine events, per mode
  always_comb begin
    if (master) begin
      lead     = m_lead;
      trail    = m_trail;
      samp     = samp_p_q[1];
      done     = last_p_q[1];
      eng_idle = (mst_q == MST_IDLE);
      in_bit   = miso_s_q;
    end else begin
      lead     = s_active && (clock_polarity_bit ? s_fall : s_rise);
      trail    = s_active && (clock_polarity_bit ? s_rise : s_fall);
      samp     = clock_phase_bit ? trail : lead;
      done     = trail && (bitc_q == (clock_phase_bit ? `SPMP_BITS_LAST : `SPMP_BITS_FULL));
      eng_idle = !s_active;
      in_bit   = mosi_s_q;
    end
  end
  assign setup = clock_phase_bit ? lead : trail;

  // shift engine
  always_ff @(posedge clk) begin
    if (rst || !en || mode_fault) begin
      bitc_q  <= `SPMP_CNT_ZERO;
      ptr_q   <= `SPMP_PTR_ZERO;
      rx_sh_q <= `SPMP_BYTE_ZERO;
      out_q   <= 1'b0;
    end else if (eng_idle && !samp && !done) begin
      bitc_q  <= `SPMP_CNT_ZERO;
      ptr_q   <= `SPMP_PTR_ZERO;
      rx_sh_q <= `SPMP_BYTE_ZERO;
      out_q   <= tx_bit(start ? bus_wdata : tx_q, `SPMP_PTR_ZERO, lsb);
    end else begin
      if (samp) begin
        rx_sh_q <= shift_in(rx_sh_q, in_bit, lsb);
        bitc_q  <= bitc_q + `SPMP_CNT_ONE;
      end
      if (setup) begin
        out_q <= tx_bit(tx_q, clock_phase_bit ? ptr_q : ptr_q + `SPMP_PTR_ONE, lsb);
        ptr_q <= ptr_q + `SPMP_PTR_ONE;
      end
      if (done) begin
        bitc_q <= `SPMP_CNT_ZERO;
        ptr_q  <= `SPMP_PTR_ZERO;
      end
    end
  end

  // single transmit buffer, receive buffer refilled at each byte end
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q     <= `SPMP_BYTE_ZERO;
      rx_buf_q <= `SPMP_BYTE_ZERO;
    end else begin
      if (data_wr && !busy) begin
        tx_q <= bus_wdata;
      end
      if (done) begin
        rx_buf_q <= samp ? shift_in(rx_sh_q, in_bit, lsb) : rx_sh_q;
      end
    end
  end

  // control register, demoted on mode fault
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `SPMP_CTRL_RST;
      dbl_q  <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= bus_wdata;
      end
      if (mode_fault) begin
        ctrl_q[`SPMP_C_ROLE] <= 1'b0;
      end
      if (stat_wr) begin
        dbl_q <= bus_wdata[`SPMP_S_DBL];
      end
    end
  end

  // status flags, a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q  <= 1'b0;
      write_collision_flag_q  <= 1'b0;
      arm_f_q <= 1'b0;
      arm_w_q <= 1'b0;
    end else begin
      if (stat_rd) begin
        arm_f_q <= flag_q;
        arm_w_q <= write_collision_flag_q;
      end else if (data_acc) begin
        arm_f_q <= 1'b0;
        arm_w_q <= 1'b0;
      end
      if (done || mode_fault) begin
        flag_q <= 1'b1;
      end else if (irq_ack || (data_acc && (arm_f_q || arm_w_q))) begin
        flag_q <= 1'b0;
      end
      if (data_wr && busy) begin
        write_collision_flag_q <= 1'b1;
      end else if (data_acc && arm_w_q) begin
        write_collision_flag_q <= 1'b0;
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !bus_rd) begin
      rdata_q <= `SPMP_BYTE_ZERO;
    end else begin
      unique case (bus_addr)
        `SPMP_OFS_CTRL: rdata_q <= ctrl_q;
        `SPMP_OFS_STAT: rdata_q <= {flag_q, write_collision_flag_q, `SPMP_S_RSVD, dbl_q};
        `SPMP_OFS_DATA: rdata_q <= rx_buf_q;
        default:        rdata_q <= `SPMP_BYTE_ZERO;
      endcase
    end
  end

  assign bus_rdata = rdata_q;
  assign irq       = ctrl_q[`SPMP_C_IE] && flag_q && cpu_gie;
  assign sck_o     = sck_q;
  assign sck_oe    = en && master;
  assign mosi_o    = out_q;
  assign mosi_oe   = en && master;
  assign miso_o    = out_q;
  assign miso_oe   = s_active;

  a_irq_request : assert property (@(posedge clk) disable iff (rst)
    $rose(flag_q) && ctrl_q[`SPMP_C_IE] && cpu_gie |-> irq)
    else $error("interrupt not raised");

  a_idle_level : assert property (@(posedge clk) disable iff (rst)
    en && master && mst_q == MST_IDLE && $stable(clock_polarity_bit) |=> sck_o == $past(clock_polarity_bit))
    else $error("serial clock not at idle level");

  a_disabled_quiet : assert property (@(posedge clk) disable iff (rst)
    !en |=> (mst_q == MST_IDLE) && !$rose(flag_q) || en)
    else $error("activity while disabled");

  a_collision_set : assert property (@(posedge clk) disable iff (rst)
    data_wr && busy |=> write_collision_flag_q && $stable(tx_q))
    else $error("collision not flagged");

  a_write_starts : assert property (@(posedge clk) disable iff (rst)
    start |=> mst_q == MST_SHIFT && tx_q == $past(bus_wdata))
    else $error("write did not start transfer");

  a_mode_fault : assert property (@(posedge clk) disable iff (rst)
    mode_fault |=> !master && flag_q && mst_q == MST_IDLE)
    else $error("mode fault not handled");

  a_slave_tristate : assert property (@(posedge clk) disable iff (rst)
    !master && ss_s_q |-> !miso_oe ##1 (bitc_q == `SPMP_CNT_ZERO || master))
    else $error("deselected slave active");

  a_reserved_zero : assert property (@(posedge clk) disable iff (rst)
    stat_rd |=> bus_rdata[5:1] == `SPMP_S_RSVD && bus_rdata[7] == $past(flag_q))
    else $error("status read wrong");

  a_read_buffer : assert property (@(posedge clk) disable iff (rst)
    data_rd |=> bus_rdata == $past(rx_buf_q))
    else $error("data read not from buffer");

  a_master_stops : assert property (@(posedge clk) disable iff (rst)
    master && done |=> mst_q == MST_IDLE && flag_q && !tick)
    else $error("master clock did not stop");

  a_fast_period : assert property (@(posedge clk) disable iff (rst)
    mst_q == MST_SHIFT && edge_q != `SPMP_EDGE_LAST && dbl_q && half == `SPMP_HALF_D2 && $stable(half) && tick |=> tick)
    else $error("doubled clock too slow");
endmodule : spmp_core

// File: tb/spmp_partner.sv
// behavioural far-side serial peripheral answering the master
`timescale 1ns/1ps
module spmp_partner (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // format and data
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  int n;
  function automatic logic pick(int k);
    return lsb ? tx[k] : tx[7 - k];
  endfunction : pick
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    n = 0;
  end
  // first bit ready before the leading edge
  always @(negedge ss_n) begin
    n = 0;
    miso = pick(0);
  end
  // a released line flips its last bit
  always @(posedge ss_n) miso = ~miso;
  // sample on leading edge when phase is zero, on trailing edge otherwise
  always @(sck) begin
    if (!ss_n && ((sck != clock_polarity_bit) != clock_phase_bit)) begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      n = n + 1;
    end else if (!ss_n && n < 8) begin
      miso = pick(n);
    end
  end
endmodule : spmp_partner

// File: tb/tb_top.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
`include "spmp_defines.svh"
module tb_top;
  import spmp_pkg::*;
  typedef struct {
    spmp_byte_t ctrl;
    logic       dbl;
    int         half;
    spmp_byte_t mtx;
    spmp_byte_t stx;
  } spmp_row_s;
  logic       clk, rst, bus_wr, bus_rd, cpu_gie, irq_ack, sck_i, mosi_i, ss_n, ss_is_input;
  logic       irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso, sck_prev;
  logic [7:0] bus_addr;
  spmp_byte_t bus_wdata, bus_rdata, cfg, stx, p_rx, s, d, g;
  spmp_row_s  rows [8];
  int         n_fail, n_compared, cyc, n_edge, t_first, t_last;

  spmp_core spmp_core_i (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_gie(cpu_gie), .irq_ack(irq_ack), .irq(irq),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(p_miso), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n),
    .ss_is_input(ss_is_input)
  );
  spmp_partner spmp_partner_i (
    .sck(sck_o), .mosi(mosi_o), .ss_n(ss_n), .miso(p_miso), .clock_polarity_bit(cfg[3]), .clock_phase_bit(cfg[2]),
    .lsb(cfg[5]), .tx(stx), .rx(p_rx)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // serial clock edge count and span in clock cycles
  always @(posedge clk) begin
    cyc++;
    if (sck_o !== sck_prev) begin
      if (n_edge == 0) t_first = cyc;
      t_last = cyc;
      n_edge++;
    end
    sck_prev = sck_o;
  end

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic wr(logic [7:0] a, spmp_byte_t v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(logic [7:0] a, output spmp_byte_t v);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
    @(posedge clk);
  endtask : rd

  task automatic wait_done(output spmp_byte_t v);
    for (int i = 0; i < 3000; i++) begin
      rd(`SPMP_OFS_STAT, v);
      if (v[`SPMP_S_DONE] === 1'b1) return;
    end
    $display("BAD done flag exp 1 got 0");
    n_fail++;
    test_done();
  endtask : wait_done

  // external master at quarter rate or slower, idle level pol, msb first
  task automatic slave_xfer(spmp_byte_t m, int nb, logic pol, output spmp_byte_t got);
    got = 8'h00;
    sck_i <= pol;
    repeat (4) @(posedge clk);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int k = 7; k >= 8 - nb; k--) begin
      repeat (2) @(posedge clk);
      mosi_i <= m[k];
      repeat (2) @(posedge clk);
      sck_i <= !pol;
      repeat (4) @(posedge clk);
      got[k] = miso_o;
      sck_i <= pol;
    end
    repeat (6) @(posedge clk);
    ss_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : slave_xfer

  initial begin
    {bus_wr, bus_rd, cpu_gie, irq_ack, sck_i, mosi_i, ss_is_input} = 7'h00;
    {bus_addr, bus_wdata, cfg, stx} = 32'h0000_0000;
    {rst, ss_n, sck_prev} = 3'b110;
    {n_fail, n_compared, cyc, n_edge} = 0;
    // mode 0..3, both orders, every rate with and without doubling
    rows = '{'{8'h50, 0, 2, 8'hA5, 8'h3C}, '{8'h75, 0, 8, 8'h01, 8'h80}, '{8'h5A, 0, 32, 8'hC3, 8'h5A},
             '{8'h7F, 0, 64, 8'h6E, 8'h17}, '{8'h70, 1, 1, 8'h0F, 8'hF0}, '{8'h55, 1, 4, 8'h92, 8'h49},
             '{8'h7A, 1, 16, 8'h33, 8'hCC}, '{8'h5F, 1, 32, 8'hE1, 8'h1E}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`SPMP_OFS_CTRL, d);
    chk("ctrl reset", 8'h00, d);
    rd(8'h33, d);
    chk("unmapped", 8'h00, d);
    chk("oe reset", 3'h0, {sck_oe, mosi_oe, miso_oe});
    wr(`SPMP_OFS_CTRL, 8'h10);
    n_edge = 0;
    wr(`SPMP_OFS_DATA, 8'h55);
    repeat (40) @(posedge clk);
    chk("edges off", 0, n_edge);
    rd(`SPMP_OFS_STAT, s);
    chk("done off", 8'h00, s & 8'hC0);
    foreach (rows[r]) begin
      cfg = rows[r].ctrl;
      stx = rows[r].stx;
      wr(`SPMP_OFS_STAT, {7'h00, rows[r].dbl});
      wr(`SPMP_OFS_CTRL, cfg);
      repeat (2) @(posedge clk);
      chk("idle sck", cfg[3], sck_o);
      n_edge = 0;
      ss_n <= 1'b0;
      wr(`SPMP_OFS_DATA, rows[r].mtx);
      wait_done(s);
      chk("reserved", 8'h00, s & 8'h3E);
      rd(`SPMP_OFS_DATA, d);
      chk("master rx", rows[r].stx, d);
      chk("far rx", rows[r].mtx, p_rx);
      chk("edges", 16, n_edge);
      chk("span", 15 * rows[r].half, t_last - t_first);
      rd(`SPMP_OFS_STAT, s);
      chk("done clr", 8'h00, s & 8'hC0);
      ss_n <= 1'b1;
      @(posedge clk);
    end
    wr(`SPMP_OFS_STAT, 8'h00);
    wr(`SPMP_OFS_CTRL, 8'hD0);
    cfg = 8'hD0;
    cpu_gie <= 1'b1;
    ss_n <= 1'b0;
    wr(`SPMP_OFS_DATA, 8'h81);
    wr(`SPMP_OFS_DATA, 8'h7E);
    wait_done(s);
    chk("collision", 8'hC0, s & 8'hC0);
    chk("irq on", 1'b1, irq);
    cpu_gie <= 1'b0;
    @(posedge clk);
    chk("irq gie", 1'b0, irq);
    cpu_gie <= 1'b1;
    rd(`SPMP_OFS_DATA, d);
    chk("first byte", 8'h81, p_rx);
    chk("rx byte", 8'h1E, d);
    rd(`SPMP_OFS_STAT, s);
    chk("both clr", 8'h00, s & 8'hC0);
    wr(`SPMP_OFS_DATA, 8'h42);
    rd(`SPMP_OFS_DATA, d);
    chk("rx hold", 8'h1E, d);
    wait_done(s);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
    chk("irq ack", 1'b0, irq);
    rd(`SPMP_OFS_STAT, s);
    chk("ack clr", 8'h00, s & 8'h80);
    ss_n <= 1'b1;
    wr(`SPMP_OFS_CTRL, 8'h50);
    ss_is_input <= 1'b1;
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`SPMP_OFS_CTRL, d);
    chk("fault ctrl", 8'h40, d);
    rd(`SPMP_OFS_STAT, s);
    chk("fault done", 8'h80, s & 8'h80);
    ss_n <= 1'b1;
    ss_is_input <= 1'b0;
    rd(`SPMP_OFS_DATA, d);
    wr(`SPMP_OFS_CTRL, 8'h43);
    wr(`SPMP_OFS_DATA, 8'hA5);
    slave_xfer(8'h3C, 8, 1'b0, g);
    chk("slave out", 8'hA5, g);
    chk("slave oe", 1'b0, miso_oe);
    wait_done(s);
    rd(`SPMP_OFS_DATA, d);
    chk("slave rx", 8'h3C, d);
    slave_xfer(8'hFF, 3, 1'b0, g);
    slave_xfer(8'h96, 8, 1'b0, g);
    wait_done(s);
    rd(`SPMP_OFS_DATA, d);
    chk("slave drop", 8'h96, d);
    wr(`SPMP_OFS_CTRL, 8'h4C);
    wr(`SPMP_OFS_DATA, 8'h5A);
    slave_xfer(8'hC3, 8, 1'b1, g);
    chk("slave m3 out", 8'h5A, g);
    wait_done(s);
    rd(`SPMP_OFS_DATA, d);
    chk("slave m3 rx", 8'hC3, d);
    test_done();
  end
endmodule : tb_top
